// File: sbwt_top.sv
`timescale 1ns/1ps
`default_nettype none
module sbwt_top (
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  input  wire logic [1:0]  SEL,
  input  wire logic [2:0]  PIN_NORMAL,
  output logic [15:0]      RDATA,
  output logic [2:0]       PIN_OUT,
  output logic [2:0]       SHAPED_OUT
);
  // ***************************************************
  // Control registers
  // ***************************************************
  logic [10:0] ctrl_reg;
  logic [15:0] cyc_reg;
  logic [15:0] cyc_stage_reg;
  logic        cyc_valid_reg;
  logic [15:0] count_reg;
  logic        down_reg;
  logic        tick;
  logic        upd;
  logic [15:0] ceiling;
  logic [1:0]  shape;
  logic        at_floor;
  logic        at_top;
  logic [15:0] thr   [sbwt_pkg::NCH];
  logic [15:0] stage [sbwt_pkg::NCH];
  logic [2:0]  valid;
  logic [2:0]  flag;
  logic [2:0]  wave;
  logic [2:0]  chen;
  logic        wr_ctrl;

  assign shape   = ctrl_reg[sbwt_pkg::CTL_SHAPE_LO +: 2];
  assign chen    = ctrl_reg[sbwt_pkg::CTL_CHEN_LO +: 3];
  assign wr_ctrl = WR && (ADDR == sbwt_pkg::ADDR_CTRL);
  // Frequency mode takes its ceiling from channel zero [R8] [R10]
  assign ceiling  = (shape == sbwt_pkg::SHAPE_FREQ) ? thr[0] : cyc_reg;
  assign at_floor = (count_reg == sbwt_pkg::ZERO16);
  assign at_top   = (count_reg == ceiling);
  // Update at ceiling for single slope and up-counting freq, floor for down-counting freq and dual [R20]
  assign upd = tick && !ctrl_reg[sbwt_pkg::CTL_LOCK] &&
               ((shape == sbwt_pkg::SHAPE_DUAL) ? (at_floor && down_reg) :
                (down_reg ? at_floor : at_top));

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_reg <= 11'h000;
    end else if (wr_ctrl) begin
      ctrl_reg <= WDATA[10:0];
    end
  end

  sbwt_prescaler u_pre (
    .clk  (REF_CLK),
    .rst  (SYS_RST),
    .run  (ctrl_reg[sbwt_pkg::CTL_EN]),
    .sel  (ctrl_reg[sbwt_pkg::CTL_DIV_LO +: 3]),
    .tick (tick)
  );

  // ***************************************************
  // Period and staging
  // ***************************************************
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cyc_reg <= sbwt_pkg::CYC_RESET;
    end else if (WR && ADDR == sbwt_pkg::ADDR_CYC_LEN) begin
      cyc_reg <= WDATA; // [R1]
    end else if (upd && cyc_valid_reg) begin
      cyc_reg <= cyc_stage_reg; // [R3]
    end
  end
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cyc_stage_reg <= sbwt_pkg::CYC_RESET;
      cyc_valid_reg <= 1'b0;
    end else if (WR && ADDR == sbwt_pkg::ADDR_CYC_STAGE) begin
      cyc_stage_reg <= WDATA;
      cyc_valid_reg <= 1'b1; // [R21]
    end else if (upd) begin
      cyc_valid_reg <= 1'b0; // [R21]
    end
  end

  // ***************************************************
  // Counter
  // ***************************************************
  // Equality only: counting up, a ceiling below count runs on to all ones and wraps [R2]
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      count_reg <= sbwt_pkg::ZERO16;
    end else if (WR && ADDR == sbwt_pkg::ADDR_COUNT) begin
      count_reg <= WDATA;
    end else if (tick) begin // [R24]
      if (shape == sbwt_pkg::SHAPE_DUAL) begin
        if (!down_reg && at_top) count_reg <= count_reg - sbwt_pkg::ONE16; // [R17] [R19]
        else if (down_reg && at_floor) count_reg <= count_reg + sbwt_pkg::ONE16;
        else if (down_reg) count_reg <= count_reg - sbwt_pkg::ONE16;
        else count_reg <= count_reg + sbwt_pkg::ONE16;
      end else if (down_reg) begin
        count_reg <= at_floor ? ceiling : count_reg - sbwt_pkg::ONE16;
      end else begin
        count_reg <= at_top ? sbwt_pkg::ZERO16 : count_reg + sbwt_pkg::ONE16; // [R22] [R16]
      end
    end
  end
  // Single slope forces up count [R14]
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      down_reg <= 1'b0;
    end else if (wr_ctrl) begin
      down_reg <= WDATA[sbwt_pkg::CTL_DOWN] &&
                  (WDATA[sbwt_pkg::CTL_SHAPE_LO +: 2] != sbwt_pkg::SHAPE_SINGLE);
    end else if (tick && shape == sbwt_pkg::SHAPE_DUAL) begin
      if (!down_reg && at_top) down_reg <= 1'b1;
      else if (down_reg && at_floor) down_reg <= 1'b0;
    end
  end

  // ***************************************************
  // Channels
  // ***************************************************
  genvar g;
  generate
    for (g = 0; g < sbwt_pkg::NCH; g++) begin : g_ch // [R23]
      // Top counts as down so a threshold at ceiling stays high
      sbwt_channel u_ch (
        .clk      (REF_CLK),
        .rst      (SYS_RST),
        .tick     (tick),
        .wr_thr   (WR && ADDR == (sbwt_pkg::ADDR_THR0 + 4'(g))),
        .wr_stage (WR && ADDR == (sbwt_pkg::ADDR_STAGE0 + 4'(g))),
        .wdata    (WDATA),
        .upd      (upd),
        .count    (count_reg),
        .shape    (shape),
        .down     (down_reg || at_top), // [R18]
        .at_floor (at_floor),
        .flag_clr (WR && ADDR == sbwt_pkg::ADDR_FLAG_CLR && WDATA[g]),
        .thr      (thr[g]),
        .stage    (stage[g]),
        .valid    (valid[g]),
        .flag     (flag[g]),
        .wave     (wave[g])
      );
    end
  endgenerate

  // ***************************************************
  // Pin override and read port
  // ***************************************************
  // Pin direction and inversion stay with the port logic outside [R7]
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PIN_OUT    <= 3'h0;
      SHAPED_OUT <= 3'h0;
    end else begin
      SHAPED_OUT <= wave;
      for (int i = 0; i < sbwt_pkg::NCH; i++) begin
        PIN_OUT[i] <= (shape != sbwt_pkg::SHAPE_NONE && chen[i]) ? wave[i] : PIN_NORMAL[i]; // [R6]
      end
    end
  end
  // Software must keep ceiling at three or more in PWM shapes [R15]
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RDATA <= sbwt_pkg::ZERO16;
    end else if (RD) begin
      unique case (ADDR)
        sbwt_pkg::ADDR_CTRL:      RDATA <= {5'h00, ctrl_reg[10:1], ctrl_reg[0]};
        sbwt_pkg::ADDR_CYC_LEN:   RDATA <= cyc_reg;
        sbwt_pkg::ADDR_CYC_STAGE: RDATA <= cyc_stage_reg;
        4'h3, 4'h4, 4'h5:         RDATA <= thr[SEL];
        4'h6, 4'h7, 4'h8:         RDATA <= stage[SEL];
        sbwt_pkg::ADDR_COUNT:     RDATA <= count_reg;
        sbwt_pkg::ADDR_STATUS:    RDATA <= {8'h00, cyc_valid_reg, valid, flag, down_reg};
        default:                  RDATA <= sbwt_pkg::ZERO16;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: sbwt_pkg.sv
// Behaviour
// (R1) Unstaged ceiling write acts at once
// (R2) Ceiling below count: run to wrap first
// (R3) Staged ceiling loads only at update
// (R4) Match sets channel flag one tick later
// (R5) Staged threshold copied at update condition
// (R6) Output drives pin when shaped and enabled
// (R7) Outside party sets pin output, inversion
// (R8) Frequency mode: threshold zero sets ceiling
// (R9) Frequency mode: toggle on own match
// (R10) Threshold zero, no prescale: half clock
// (R11) Channels 1,2 toggle within zero cycle
// (R12) Single slope: set floor, clear match
// (R13) Single slope static low/high corner cases
// (R14) Single slope counts up only
// (R15) Software keeps ceiling at least three
// (R16) Single slope period ceiling plus one
// (R17) Dual slope: clear up, set down
// (R18) Dual slope static low/high corner cases
// (R19) Dual slope period twice ceiling ticks
// (R20) Update at floor/ceiling unless locked
// (R21) Valid flag set on write, cleared on update
// (R22) Up count wraps to zero after ceiling
// (R23) Three compare channels share one counter
// (R24) Counter advances on prescaled ticks only
package sbwt_pkg;
  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_CYC_LEN   = 4'h1;
  localparam logic [3:0] ADDR_CYC_STAGE = 4'h2;
  localparam logic [3:0] ADDR_THR0      = 4'h3;
  localparam logic [3:0] ADDR_STAGE0    = 4'h6;
  localparam logic [3:0] ADDR_COUNT     = 4'h9;
  localparam logic [3:0] ADDR_STATUS    = 4'hA;
  localparam logic [3:0] ADDR_FLAG_CLR  = 4'hB;
  localparam int         NCH            = 3;
  // Control fields
  localparam int         CTL_EN         = 0;
  localparam int         CTL_DIV_LO     = 1;
  localparam int         CTL_SHAPE_LO   = 4;
  localparam int         CTL_CHEN_LO    = 6;
  localparam int         CTL_LOCK       = 9;
  localparam int         CTL_DOWN       = 10;
  localparam logic [15:0] CYC_RESET     = 16'hFFFF;
  localparam logic [15:0] ZERO16        = 16'h0000;
  localparam logic [15:0] ONE16         = 16'h0001;
  typedef enum logic [1:0] {
    SHAPE_NONE, SHAPE_FREQ, SHAPE_SINGLE, SHAPE_DUAL
  } sbwt_shape_e;
endpackage

// File: sbwt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module sbwt_prescaler (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [9:0] cnt_reg;
  logic [9:0] lim;
  always_comb begin
    unique case (sel)
      3'h0: lim = 10'h000;
      3'h1: lim = 10'h001;
      3'h2: lim = 10'h003;
      3'h3: lim = 10'h007;
      3'h4: lim = 10'h00F;
      3'h5: lim = 10'h03F;
      3'h6: lim = 10'h0FF;
      3'h7: lim = 10'h3FF;
    endcase
  end
  // Divide by 1,2,4,8,16,64,256,1024 [R24]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 10'h000;
      tick    <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 10'h000;
      tick    <= 1'b0;
    end else if (cnt_reg >= lim) begin
      cnt_reg <= 10'h000;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 10'h001;
      tick    <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: sbwt_channel.sv
`timescale 1ns/1ps
`default_nettype none
module sbwt_channel (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        wr_thr,
  input  wire logic        wr_stage,
  input  wire logic [15:0] wdata,
  input  wire logic        upd,
  input  wire logic [15:0] count,
  input  wire logic [1:0]  shape,
  input  wire logic        down,
  input  wire logic        at_floor,
  input  wire logic        flag_clr,
  output logic [15:0]      thr,
  output logic [15:0]      stage,
  output logic             valid,
  output logic             flag,
  output logic             wave
);
  logic match;
  assign match = (count == thr); // [R4]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thr <= sbwt_pkg::ZERO16;
    end else if (wr_thr) begin
      thr <= wdata;
    end else if (upd && valid) begin
      thr <= stage; // [R5]
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage <= sbwt_pkg::ZERO16;
      valid <= 1'b0;
    end else if (wr_stage) begin
      stage <= wdata;
      valid <= 1'b1; // [R21]
    end else if (upd) begin
      valid <= 1'b0; // [R21]
    end
  end
  // Set beats clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (tick && match) begin
      flag <= 1'b1; // [R4]
    end else if (flag_clr) begin
      flag <= 1'b0;
    end
  end
  // Match at floor wins so threshold at floor stays low [R13] [R18]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wave <= 1'b0;
    end else if (tick) begin
      unique case (shape)
        sbwt_pkg::SHAPE_FREQ: if (match) wave <= ~wave; // [R9] [R11]
        sbwt_pkg::SHAPE_SINGLE: begin
          if (match) wave <= 1'b0; // [R12]
          else if (at_floor) wave <= 1'b1;
        end
        sbwt_pkg::SHAPE_DUAL: begin
          if (match) wave <= down && !at_floor; // [R17] [R18]
          else if (at_floor) wave <= 1'b1;
        end
        default: wave <= 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: sbwt_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sbwt_top_sva (
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  input wire logic [3:0]  ADDR,
  input wire logic [15:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [1:0]  SEL,
  input wire logic [2:0]  PIN_NORMAL,
  input wire logic [15:0] RDATA,
  input wire logic [2:0]  PIN_OUT,
  input wire logic [2:0]  SHAPED_OUT
);
  // *****
  // Shadow of software writes
  // *****
  // Staged transfers are not shadowed, so checks lean on direct writes only
  logic [15:0] ctrl_reg;
  logic [15:0] thr_reg;
  logic [2:0]  quiet_reg;
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_reg  <= 16'h0000;
      thr_reg   <= 16'h0000;
      quiet_reg <= 3'h0;
    end else begin
      if (WR && ADDR == 4'h0) ctrl_reg <= WDATA;
      if (WR && ADDR == 4'h3) thr_reg <= WDATA;
      if (WR) quiet_reg <= 3'h0;
      else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // *****
  // Properties
  // *****
  sequence s_wr_rd(wa, ra);
    WR && ADDR == wa ##1 RD && ADDR == ra;
  endsequence
  sequence s_cnt2;
    RD && ADDR == 4'h9 ##1 RD && ADDR == 4'h9;
  endsequence
  property p_pin_norm;
    !$past(SYS_RST) && ctrl_reg[5:4] == 2'h0 && $stable(ctrl_reg) |-> PIN_OUT == $past(PIN_NORMAL);
  endproperty
  property p_pin_wave;
    ctrl_reg[5:4] != 2'h0 && ctrl_reg[8:6] == 3'h7 && $stable(ctrl_reg) |-> PIN_OUT == SHAPED_OUT;
  endproperty
  property p_freq_half;
    ctrl_reg[5:0] == 6'h11 && thr_reg == 16'h0000 && quiet_reg == 3'h7
      |-> SHAPED_OUT[0] != $past(SHAPED_OUT[0]);
  endproperty
  property p_flag;
    ctrl_reg[5:0] == 6'h11 && thr_reg == 16'h0000 && quiet_reg == 3'h7 && RD && ADDR == 4'hA
      |=> RDATA[1];
  endproperty
  property p_cnt_step;
    ctrl_reg[5:0] == 6'h01 && !ctrl_reg[10] && quiet_reg == 3'h7 ##0 s_cnt2
      |=> RDATA == $past(RDATA) + 16'h0001 || RDATA == 16'h0000;
  endproperty
  property p_cyc_rb;
    s_wr_rd(4'h1, 4'h1) |=> RDATA == $past(WDATA, 2);
  endproperty
  property p_thr_rb;
    SEL == 2'h0 ##0 s_wr_rd(4'h3, 4'h3) |=> RDATA == $past(WDATA, 2);
  endproperty
  property p_valid;
    !ctrl_reg[0] ##0 s_wr_rd(4'h2, 4'hA) |=> RDATA[7];
  endproperty
  a_pin_norm: assert property (p_pin_norm)
    else $error("pin not normal value");
  a_pin_wave: assert property (p_pin_wave)
    else $error("pin not waveform");
  a_freq_half: assert property (p_freq_half)
    else $error("no toggle each clock");
  a_flag: assert property (p_flag)
    else $error("match flag missing");
  a_cnt_step: assert property (p_cnt_step)
    else $error("count step wrong");
  a_cyc_rb: assert property (p_cyc_rb)
    else $error("ceiling not immediate");
  a_thr_rb: assert property (p_thr_rb)
    else $error("threshold readback wrong");
  a_valid: assert property (p_valid)
    else $error("staging valid not set");
endmodule
bind sbwt_top sbwt_top_sva SVA (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .SEL(SEL), .PIN_NORMAL(PIN_NORMAL), .RDATA(RDATA), .PIN_OUT(PIN_OUT),
  .SHAPED_OUT(SHAPED_OUT)
);
`default_nettype wire

// File: sbwt_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbwt_pin_model (
  input  wire logic [2:0] drv,
  input  wire logic [2:0] dir,
  input  wire logic [2:0] inv,
  output logic [2:0]      pad
);
  // *****
  // Port pins
  // *****
  // Released pins fall to the pull-up, never the last value
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pad[i] = dir[i] ? drv[i] ^ inv[i] : 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: test_sbwt_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_sbwt_top;
  // *****
  // Harness
  // *****
  logic        clk;
  logic        rst;
  logic        wr;
  logic        rd;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] q;
  logic [1:0]  sel;
  logic [2:0]  pn;
  logic [2:0]  pout;
  logic [2:0]  sout;
  logic [2:0]  pad;
  int          fail_count;
  int          n_checks;
  int          h[3];
  int          tg;
  sbwt_top DUT (.REF_CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .SEL(sel), .PIN_NORMAL(pn), .RDATA(rdata), .PIN_OUT(pout), .SHAPED_OUT(sout));
  sbwt_pin_model PINS (.drv(pout), .dir(3'h7), .inv(3'h2), .pad(pad));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobes stay up until the next call, so no signal is set twice per step
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    wr    <= w;
    rd    <= r;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 4'h0, 16'h0000);
  endtask
  task automatic wrr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic get(input logic [3:0] a);
    bus(1'b0, 1'b1, a, 16'h0000);
    q = rdata;
  endtask
  task automatic rs;
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    idle(1);
  endtask
  task automatic meas(input int n);
    logic p;
    h = '{0, 0, 0};
    tg = 0;
    p = sout[0];
    repeat (n) begin
      idle(1);
      for (int i = 0; i < 3; i++) h[i] += sout[i];
      tg += int'(sout[0] != p);
      p = sout[0];
    end
  endtask
  // *****
  // Scenarios
  // *****
  task automatic t_regs;
    rs();
    sel <= 2'h0;
    wrr(4'h1, 16'h1234);
    get(4'h1);
    chk(q, 16'h1234);
    wrr(4'h2, 16'h0055);
    get(4'hA);
    chk({15'h0, q[7]}, 16'h0001);
    wrr(4'h3, 16'h0042);
    get(4'h3);
    chk(q, 16'h0042);
    idle(1);
    $display("t_regs done");
  endtask
  task automatic t_freq;
    rs();
    wrr(4'h0, 16'h01D1);
    idle(8);
    meas(16);
    chk(16'(tg), 16'h0010);
    chk(16'(h[1] + h[2]), 16'h0010);
    get(4'hA);
    chk({15'h0, q[1]}, 16'h0001);
    wrr(4'h3, 16'h0003);
    idle(8);
    meas(16);
    chk(16'(tg), 16'h0004);
    $display("t_freq done");
  endtask
  task automatic t_r2;
    rs();
    pn <= 3'h6;
    wrr(4'h0, 16'h0001);
    idle(200);
    chk({13'h0, pout}, 16'h0006);
    chk({13'h0, pad}, 16'h0004);
    wrr(4'h1, 16'h000A);
    idle(8);
    bus(1'b0, 1'b1, 4'h9, 16'h0000);
    get(4'h9);
    chk({15'h0, q > 16'h000A}, 16'h0001);
    wrr(4'h0, 16'h0003);
    get(4'h9);
    tg = q;
    idle(9);
    get(4'h9);
    chk(q - 16'(tg), 16'h0005);
    idle(1);
    $display("t_r2 done");
  endtask
  task automatic pwm(input logic [15:0] c, p, a, b, input int e);
    rs();
    wrr(4'h1, p);
    wrr(4'h3, a);
    wrr(4'h4, 16'h0000);
    wrr(4'h5, b);
    wrr(4'h0, c);
    idle(20);
    meas(16);
    chk(16'(h[0]), 16'(e));
    chk(16'(h[1]), 16'h0000);
    chk(16'(h[2]), 16'h0010);
    $display("pwm %h done", c);
  endtask
  task automatic t_stage;
    rs();
    wrr(4'h1, 16'h0007);
    wrr(4'h0, 16'h01E1);
    wrr(4'h6, 16'h0005);
    get(4'hA);
    chk({15'h0, q[4]}, 16'h0001);
    idle(20);
    get(4'hA);
    chk({15'h0, q[4]}, 16'h0000);
    get(4'h3);
    chk(q, 16'h0005);
    wrr(4'h0, 16'h03E1);
    wrr(4'h6, 16'h0002);
    wrr(4'h2, 16'h0003);
    idle(20);
    get(4'h3);
    chk(q, 16'h0005);
    wrr(4'h0, 16'h01E1);
    idle(20);
    get(4'h1);
    chk(q, 16'h0003);
    wrr(4'h0, 16'h05E1);
    get(4'hA);
    chk({15'h0, q[0]}, 16'h0000);
    idle(1);
    $display("t_stage done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    sel = 2'h0;
    pn = 3'h1;
    fail_count = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    #1;
    rst <= 1'b0;
    idle(1);
    t_regs();
    t_freq();
    t_r2();
    pwm(16'h01E1, 16'h0007, 16'h0003, 16'h0009, 6);
    pwm(16'h01F1, 16'h0004, 16'h0002, 16'h0004, 8);
    t_stage();
    report_and_stop();
  end
endmodule
`default_nettype wire
